// *** design/battery_status_charge_request.sv ***
// status word, charge requests and time estimates with a read-word port
// assumes gauge measurements arrive on clk_sys, requests on clkLink
`timescale 1ns/100ps
`default_nettype none
`include "battery_status_defines.svh"

module battery_status_charge_request
  import battery_status_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // read-word link
  input wire logic clkLink,
  input wire logic linkReqValid,
  input wire logic [7:0] linkCmd,
  output logic linkReqReady,
  output logic linkRespValid,
  output logic [15:0] linkRespData,
  output logic linkRespUnsupported,
  // charge state
  input wire logic charging,
  input wire logic primaryTerm,
  input wire logic mahTick,
  input wire logic [15:0] chargedAccum,
  input wire logic [15:0] fullCap,
  input wire logic [15:0] maxOvercharge,
  // temperature
  input wire logic [15:0] tempNow,
  input wire logic [15:0] otChgSet,
  input wire logic [15:0] otChgReset,
  input wire logic [15:0] otDsgSet,
  input wire logic [15:0] otDsgReset,
  input wire logic [15:0] suspendTempLow,
  // voltage and current
  input wire logic [15:0] voltageNow,
  input wire logic [15:0] cellVoltage,
  input wire logic [15:0] terminateVoltage,
  input wire logic [15:0] secondEndOfDischargeThreshold,
  input wire logic cellUndervoltageFlag,
  input wire logic signed [15:0] currentNow,
  input wire logic signed [15:0] overloadCurrent,
  // capacity and time
  input wire logic capacityMode,
  input wire logic [15:0] remCapCharge,
  input wire logic [15:0] remCapEnergy,
  input wire logic [15:0] capacityAlarmThreshold,
  input wire logic [15:0] timeAlarmThreshold,
  input wire logic [15:0] runTimeCurrent,
  input wire logic [15:0] runTimePower,
  input wire logic [15:0] avgTimeToFullRaw,
  input wire logic [15:0] avgTteCurrent,
  input wire logic [15:0] avgTtePower,
  input wire logic [7:0] relativeChargePercent,
  input wire logic [7:0] fullyChargedClearPct,
  input wire logic [7:0] batteryLowPct,
  // flash load and command results
  input wire logic flashLoadValid,
  input wire logic flashLoadBad,
  input wire logic errReportValid,
  input wire logic [2:0] errReportCode,
  // charger requests
  input wire logic [15:0] chargeCurrentRaw,
  input wire logic [15:0] chargeVoltageRaw,
  input wire logic chargerOff,
  input wire logic cvModeReq,
  input wire logic ccModeReq,
  // reported values
  output logic [15:0] avgTimeToFull,
  output logic [15:0] avgTimeToEmpty,
  output logic [15:0] chargeCurrentRequest,
  output logic [15:0] chargeVoltageRequest,
  output logic [15:0] packStatusWord,
  output logic [15:0] alarmBroadcastWord,
  output logic alarmBroadcastStrobe
);

  sys_state_t s;
  sys_state_t n;
  logic reqToggle;
  logic [7:0] cmdHeld;
  logic [15:0] statusNow;
  logic [15:0] statusNxt;
  logic [15:0] remCap;
  logic [15:0] runTime;
  logic [15:0] tteRaw;
  logic [16:0] ovcLimit;
  logic ovcOver;
  logic cmdMapped;
  logic fullDsgSet;

  link_read_port u_link
  (
    .clkLink(clkLink),
    .rst(rst),
    .linkReqValid(linkReqValid),
    .linkCmd(linkCmd),
    .linkReqReady(linkReqReady),
    .linkRespValid(linkRespValid),
    .linkRespData(linkRespData),
    .linkRespUnsupported(linkRespUnsupported),
    .reqToggle(reqToggle),
    .cmdHeld(cmdHeld),
    .ackToggle(s.ackTog),
    .sysRespData(s.respData),
    .sysRespBad(s.respBad)
  );

  // capacity units follow the mode bit
  assign remCap = capacityMode ? remCapEnergy : remCapCharge;
  // remaining-time figures follow the same mode
  assign runTime = capacityMode ? runTimePower : runTimeCurrent;
  assign tteRaw = capacityMode ? avgTtePower : avgTteCurrent;
  assign ovcLimit = {1'b0, fullCap} + {1'b0, maxOvercharge};
  assign ovcOver = charging && ({1'b0, chargedAccum} > ovcLimit);
  assign fullDsgSet = (((voltageNow < secondEndOfDischargeThreshold) ||
    (cellVoltage < secondEndOfDischargeThreshold)) &&
    (currentNow < overloadCurrent)) ||
    (relativeChargePercent < batteryLowPct);
  assign cmdMapped = (cmdHeld == `CMD_AVG_TIME_TO_FULL) ||
    (cmdHeld == `CMD_CHARGE_CURRENT) ||
    (cmdHeld == `CMD_CHARGE_VOLTAGE) ||
    (cmdHeld == `CMD_PACK_STATUS);

  function automatic logic [15:0] pack_word(input sys_state_t f);
    logic [15:0] w;
    w = `ZERO16;
    w[`SB_OVER_CHARGED] = f.ovChg;
    w[`SB_TERM_CHARGE] = f.termChg;
    w[`SB_RSVD_HI] = 1'b0;
    w[`SB_OVER_TEMP] = f.overTemp;
    w[`SB_TERM_DISCHARGE] = f.termDsg;
    w[`SB_RSVD_LO] = 1'b0;
    w[`SB_LOW_CAPACITY] = f.lowCap;
    w[`SB_LOW_TIME] = f.lowTime;
    w[`SB_INITIALIZED] = f.init;
    w[`SB_DISCHARGING] = f.dsg;
    w[`SB_FULLY_CHARGED] = f.fullChg;
    w[`SB_FULLY_DISCHARGED] = f.fullDsg;
    w[`SB_ERR_HI:`SB_ERR_LO] = f.err;
    return w;
  endfunction

  always_comb
  begin
    n = s;
    n.reqS1 = reqToggle;
    n.reqS2 = s.reqS1;
    n.alarmStb = 1'b0;
    // reported time values
    n.ttf = charging ? ((avgTimeToFullRaw > `TIME_MAX) ? `TIME_MAX :
      avgTimeToFullRaw) : `TIME_INVALID;
    n.tte = !charging ? ((tteRaw > `TIME_MAX) ? `TIME_MAX : tteRaw) :
      `TIME_INVALID;
    // charger requests; off wins over the constant-voltage code on the current request only
    if (chargerOff)
      n.chgI = `REQ_OFF;
    else if (cvModeReq)
      n.chgI = `REQ_BEYOND;
    else
      n.chgI = chargeCurrentRaw;
    n.chgV = ccModeReq ? `REQ_BEYOND : chargeVoltageRaw;
    // overcharge: mAh count restarts whenever charging resumes
    if (charging)
      n.ovcMah = 2'h0;
    else if (mahTick && (s.ovcMah != `OVC_CLEAR_MAH))
      n.ovcMah = s.ovcMah + 2'h1;
    if (ovcOver)
      n.ovChg = 1'b1;
    else if (!charging && (s.ovcMah == `OVC_CLEAR_MAH))
      n.ovChg = 1'b0;
    // termination alarm; the set wins over the clear
    if (primaryTerm)
      n.termChg = 1'b1;
    else if (!charging)
      n.termChg = 1'b0;
    // over-temperature with direction-matched thresholds
    if ((charging && (tempNow >= otChgSet)) ||
        (!charging && (tempNow >= otDsgSet)))
      n.overTemp = 1'b1;
    else if (charging ? (tempNow < otChgReset) : (tempNow < otDsgReset))
      n.overTemp = 1'b0;
    if ((remCap == `ZERO16) || (voltageNow == terminateVoltage) ||
        (tempNow <= suspendTempLow) || cellUndervoltageFlag)
      n.termDsg = 1'b1;
    else if ((voltageNow > terminateVoltage) && (remCap != `ZERO16) &&
        !cellUndervoltageFlag)
      n.termDsg = 1'b0;
    if (remCap < capacityAlarmThreshold)
      n.lowCap = 1'b1;
    else if ((capacityAlarmThreshold < remCap) ||
        (charging && (remCap > s.prevCap)))
      n.lowCap = 1'b0;
    if (runTime < timeAlarmThreshold)
      n.lowTime = 1'b1;
    else if ((timeAlarmThreshold < s.tte) ||
        (charging && (s.tte > s.prevTte)))
      n.lowTime = 1'b0;
    n.prevCap = remCap;
    n.prevTte = s.tte;
    // flash load result
    if (flashLoadValid)
      n.init = 1'b1;
    else if (flashLoadBad)
      n.init = 1'b0;
    n.dsg = !charging;
    if (primaryTerm || ovcOver)
      n.fullChg = 1'b1;
    else if (relativeChargePercent < fullyChargedClearPct)
      n.fullChg = 1'b0;
    if (fullDsgSet)
      n.fullDsg = 1'b1;
    else if (relativeChargePercent >= `FULL_DSG_CLEAR_PCT)
      n.fullDsg = 1'b0;
    // command result from the rest of the gauge
    if (errReportValid)
      n.err = errReportCode;
    // read-word answer
    case (s.st)
      ST_IDLE:
      begin
        if (s.reqS2 != s.reqSeen)
        begin
          n.reqSeen = s.reqS2;
          n.st = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        // command held still by the link side until the ack returns
        case (cmdHeld)
          `CMD_AVG_TIME_TO_FULL: n.respData = s.ttf;
          `CMD_CHARGE_CURRENT: n.respData = s.chgI;
          `CMD_CHARGE_VOLTAGE: n.respData = s.chgV;
          `CMD_PACK_STATUS: n.respData = statusNow;
          default: n.respData = `ZERO16;
        endcase
        n.respBad = !cmdMapped;
        n.ackTog = ~s.ackTog;
        n.st = ST_ANSWER;
      end
      ST_ANSWER:
      begin
        // the read's own result beats a same-cycle external report
        n.err = cmdMapped ? `ERR_OK : `ERR_UNSUPPORTED;
        n.st = ST_IDLE;
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase
    // broadcast on any alarm that newly rises
    statusNxt = pack_word(n);
    if ((statusNxt[`SB_OVER_CHARGED:`SB_LOW_TIME] &
        ~statusNow[`SB_OVER_CHARGED:`SB_LOW_TIME]) != 8'h00)
    begin
      n.alarmWord = statusNxt | `SB_ERR_MASK;
      n.alarmStb = 1'b1;
    end
    if (rst)
    begin
      n = '0;
      n.st = ST_IDLE;
      n.ttf = `TIME_INVALID;
      n.tte = `TIME_INVALID;
      n.prevTte = `TIME_INVALID;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s <= n;
  end

  assign statusNow = pack_word(s);
  assign avgTimeToFull = s.ttf;
  assign avgTimeToEmpty = s.tte;
  assign chargeCurrentRequest = s.chgI;
  assign chargeVoltageRequest = s.chgV;
  assign packStatusWord = statusNow;
  assign alarmBroadcastWord = s.alarmWord;
  assign alarmBroadcastStrobe = s.alarmStb;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence seqNewReq;
    (s.st == ST_IDLE) && (s.reqS2 != s.reqSeen);
  endsequence

  sequence seqAckFlip;
    $changed(s.ackTog) && (s.st == ST_ANSWER);
  endsequence

  AST_ANSWER_TIMING: assert property (seqNewReq |-> ##2 seqAckFlip)
    else $error("read answer not toggled two cycles after request");

  AST_TTF_INVALID: assert property (!charging |=>
    avgTimeToFull == `TIME_INVALID)
    else $error("time-to-full not invalid while not charging");

  AST_TTE_INVALID: assert property (charging |=>
    avgTimeToEmpty == `TIME_INVALID)
    else $error("time-to-empty not invalid while charging");

  AST_CHG_OFF: assert property (chargerOff |=>
    chargeCurrentRequest == `REQ_OFF)
    else $error("charger off not reported as zero current");

  AST_CV_MODE: assert property (cvModeReq && !chargerOff |=>
    chargeCurrentRequest == `REQ_BEYOND)
    else $error("constant-voltage request not reported");

  AST_CC_MODE: assert property (ccModeReq |=>
    chargeVoltageRequest == `REQ_BEYOND)
    else $error("constant-current request not reported");

  AST_RESERVED_ZERO: assert property (!packStatusWord[`SB_RSVD_HI] &&
    !packStatusWord[`SB_RSVD_LO])
    else $error("reserved status bit reads one");

  AST_BROADCAST_ERR: assert property (alarmBroadcastStrobe |->
    alarmBroadcastWord == (packStatusWord | `SB_ERR_MASK))
    else $error("broadcast word differs from status with error ones");

  AST_UNSUPPORTED: assert property ((s.st == ST_DECODE) && !cmdMapped
    |=> s.respBad ##1 (packStatusWord[`SB_ERR_HI:`SB_ERR_LO] ==
    `ERR_UNSUPPORTED))
    else $error("unmapped read not flagged unsupported");

  AST_TERM_CHG_CLEAR: assert property (!charging && !primaryTerm |=>
    !packStatusWord[`SB_TERM_CHARGE])
    else $error("terminate-charge alarm held while not charging");

  AST_OVC_SET: assert property (ovcOver |=>
    packStatusWord[`SB_OVER_CHARGED] && packStatusWord[`SB_FULLY_CHARGED])
    else $error("overcharge did not raise alarm and full flag");

  AST_EMPTY_ALARM: assert property (remCap == `ZERO16 |=>
    packStatusWord[`SB_TERM_DISCHARGE])
    else $error("empty pack did not raise terminate-discharge");

  AST_DSG_FLAG: assert property (charging |=>
    !packStatusWord[`SB_DISCHARGING] ##1 1'b1)
    else $error("discharging flag set while charging");

endmodule
`default_nettype wire

// *** pkg/battery_status_defines.svh ***
// constants of the battery status and charge request block
// assumes inclusion by the design files only
//
// Behaviour
// - time-to-full in minutes up to 65,534; 65,535 while not charging
// - average time-to-empty up to 65,534; 65,535 while not discharging
// - charge current request in mA; zero turns the charger off
// - current request 65,535 asks for constant-voltage operation
// - voltage request in mV; 65,535 asks for constant-current operation
// - status word: six alarm bits, two reserved, four status flags
// - low three status bits carry the last command result code
// - alarm broadcast sends the status word with error bits all ones
// - overcharge alarm set past limit, cleared after 2 mAh not charging
// - terminate-charge alarm set on termination, cleared when not charging
// - over-temperature alarm per charge or discharge thresholds
// - terminate-discharge alarm on empty, terminate voltage, cold, undervoltage
// - low-capacity alarm against host threshold, cleared on rise
// - low-time alarm against host threshold, cleared on rise
// - remaining-time alarm uses current or power per capacity mode
// - initialized flag follows valid or improper flash load
// - discharging flag set whenever not charging
// - fully-charged set on termination or overcharge, cleared below clear %
// - fully-discharged set on low voltage or low %, cleared at 20%
// - capacity mode selects charge units or 10 mWh energy units
`ifndef BATTERY_STATUS_DEFINES_SVH
`define BATTERY_STATUS_DEFINES_SVH

`define CMD_AVG_TIME_TO_FULL 8'h13
`define CMD_CHARGE_CURRENT 8'h14
`define CMD_CHARGE_VOLTAGE 8'h15
`define CMD_PACK_STATUS 8'h16

`define TIME_INVALID 16'hffff
`define TIME_MAX 16'hfffe
`define REQ_OFF 16'h0000
`define REQ_BEYOND 16'hffff
`define ZERO16 16'h0000

`define SB_OVER_CHARGED 4'hf
`define SB_TERM_CHARGE 4'he
`define SB_RSVD_HI 4'hd
`define SB_OVER_TEMP 4'hc
`define SB_TERM_DISCHARGE 4'hb
`define SB_RSVD_LO 4'ha
`define SB_LOW_CAPACITY 4'h9
`define SB_LOW_TIME 4'h8
`define SB_INITIALIZED 4'h7
`define SB_DISCHARGING 4'h6
`define SB_FULLY_CHARGED 4'h5
`define SB_FULLY_DISCHARGED 4'h4
`define SB_ERR_HI 4'h2
`define SB_ERR_LO 4'h0
`define SB_ERR_MASK 16'h0007

`define ERR_OK 3'h0
`define ERR_BUSY 3'h1
`define ERR_RESERVED 3'h2
`define ERR_UNSUPPORTED 3'h3
`define ERR_ALL_ONES 3'h7

`define OVC_CLEAR_MAH 2'h2
`define FULL_DSG_CLEAR_PCT 8'h14

`endif

// *** pkg/battery_status_pkg.sv ***
// types of the battery status and charge request block
// assumes the defines header sits beside it
`default_nettype none
package battery_status_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_DECODE = 2'h1,
    ST_ANSWER = 2'h3
  } ans_state_t;

  typedef struct packed
  {
    logic rstS1;
    logic rstS2;
    logic ackS1;
    logic ackS2;
    logic ackSeen;
    logic reqTog;
    logic busy;
    logic [7:0] cmd;
    logic respValid;
    logic [15:0] respData;
    logic respBad;
  } link_state_t;

  typedef struct packed
  {
    logic reqS1;
    logic reqS2;
    logic reqSeen;
    logic ackTog;
    ans_state_t st;
    logic [15:0] respData;
    logic respBad;
    logic ovChg;
    logic termChg;
    logic overTemp;
    logic termDsg;
    logic lowCap;
    logic lowTime;
    logic init;
    logic dsg;
    logic fullChg;
    logic fullDsg;
    logic [2:0] err;
    logic [1:0] ovcMah;
    logic [15:0] prevCap;
    logic [15:0] prevTte;
    logic [15:0] ttf;
    logic [15:0] tte;
    logic [15:0] chgI;
    logic [15:0] chgV;
    logic [15:0] alarmWord;
    logic alarmStb;
  } sys_state_t;

endpackage
`default_nettype wire

// *** design/link_read_port.sv ***
// link-clock side of the read-word port
// assumes the system side answers a request toggle with an ack toggle
`timescale 1ns/100ps
`default_nettype none
`include "battery_status_defines.svh"

module link_read_port
  import battery_status_pkg::*;
(
  // link clock and system reset
  input wire logic clkLink,
  input wire logic rst,
  // link requests
  input wire logic linkReqValid,
  input wire logic [7:0] linkCmd,
  output logic linkReqReady,
  output logic linkRespValid,
  output logic [15:0] linkRespData,
  output logic linkRespUnsupported,
  // crossing to the system domain
  output logic reqToggle,
  output logic [7:0] cmdHeld,
  input wire logic ackToggle,
  input wire logic [15:0] sysRespData,
  input wire logic sysRespBad
);

  link_state_t s;
  link_state_t n;

  always_comb
  begin
    n = s;
    n.rstS1 = rst;
    n.rstS2 = s.rstS1;
    n.ackS1 = ackToggle;
    n.ackS2 = s.ackS1;
    n.respValid = 1'b0;
    if (s.rstS2)
    begin
      n.ackSeen = 1'b0;
      n.reqTog = 1'b0;
      n.busy = 1'b0;
      n.cmd = 8'h00;
      n.respData = `ZERO16;
      n.respBad = 1'b0;
    end
    else if (s.busy && (s.ackS2 != s.ackSeen))
    begin
      // answer words are held still by the system side until next toggle
      n.ackSeen = s.ackS2;
      n.respValid = 1'b1;
      n.respData = sysRespData;
      n.respBad = sysRespBad;
      n.busy = 1'b0;
    end
    else if (!s.busy && linkReqValid)
    begin
      n.cmd = linkCmd;
      n.reqTog = ~s.reqTog;
      n.busy = 1'b1;
    end
  end

  always_ff @(posedge clkLink)
  begin
    s <= n;
  end

  // one request in flight; the command stays put while busy
  assign linkReqReady = !s.busy && !s.rstS2;
  assign linkRespValid = s.respValid;
  assign linkRespData = s.respData;
  assign linkRespUnsupported = s.respBad;
  assign reqToggle = s.reqTog;
  assign cmdHeld = s.cmd;

endmodule
`default_nettype wire

// *** testbench/link_host_model.sv ***
// host model issuing read-word requests on the link
// assumes the bench calls read() and the block answers within a few cycles
`timescale 1ns/100ps
`default_nettype none

module link_host_model
(
  // link clock and request
  output logic clkLink,
  output logic linkReqValid,
  output logic [7:0] linkCmd,
  // answer
  input wire logic linkReqReady,
  input wire logic linkRespValid,
  input wire logic [15:0] linkRespData,
  input wire logic linkRespUnsupported
);
  logic clkRun;

  initial
  begin
    clkLink = 1'b0;
    clkRun = 1'b1;
    linkReqValid = 1'b0;
    linkCmd = 8'h00;
  end

  // clock parks low between requests, as a real host would
  always
  begin
    #24;
    if (clkRun || clkLink)
      clkLink = ~clkLink;
  end

  task automatic read(input logic [7:0] code, output logic [15:0] data,
    output logic unsup, output logic ok);
    int n;
    logic seen;
    ok = 1'b0;
    data = 16'h0000;
    unsup = 1'b0;
    seen = 1'b0;
    clkRun = 1'b1;
    // restarted clock needs edges before a request
    repeat (4) @(posedge clkLink);
    #2;
    linkReqValid = 1'b1;
    linkCmd = code;
    for (n = 0; n < 12 && !seen; n++)
    begin
      @(negedge clkLink);
      seen = (linkReqReady === 1'b1);
      @(posedge clkLink);
    end
    #2;
    linkReqValid = 1'b0;
    // released command lines do not keep the old value
    linkCmd = ~code;
    for (n = 0; n < 12 && !ok; n++)
    begin
      @(negedge clkLink);
      if (linkRespValid === 1'b1)
      begin
        data = linkRespData;
        unsup = linkRespUnsupported;
        ok = seen;
      end
    end
    repeat (2) @(posedge clkLink);
    clkRun = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** testbench/battery_status_charge_request_test.sv ***
// self-checking bench for status word and charge requests
// assumes the link host model drives the read-word port
`timescale 1ns/100ps
`default_nettype none

module battery_status_charge_request_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic charging, primaryTerm, mahTick, cellUndervoltageFlag, capacityMode;
  logic flashLoadValid, flashLoadBad, errReportValid, chargerOff;
  logic cvModeReq, ccModeReq, alarmBroadcastStrobe;
  logic [2:0] errReportCode;
  logic [7:0] relativeChargePercent, fullyChargedClearPct, batteryLowPct;
  logic signed [15:0] currentNow, overloadCurrent;
  logic [15:0] chargedAccum, fullCap, maxOvercharge, tempNow, otChgSet;
  logic [15:0] otChgReset, otDsgSet, otDsgReset, suspendTempLow, voltageNow;
  logic [15:0] cellVoltage, terminateVoltage, secondEndOfDischargeThreshold;
  logic [15:0] remCapCharge, remCapEnergy, capacityAlarmThreshold;
  logic [15:0] timeAlarmThreshold, runTimeCurrent, runTimePower;
  logic [15:0] avgTimeToFullRaw, avgTteCurrent, avgTtePower;
  logic [15:0] chargeCurrentRaw, chargeVoltageRaw;
  logic clkLink, linkReqValid, linkReqReady, linkRespValid;
  logic linkRespUnsupported;
  logic [7:0] linkCmd;
  logic [15:0] linkRespData, avgTimeToFull, avgTimeToEmpty;
  logic [15:0] chargeCurrentRequest, chargeVoltageRequest, packStatusWord;
  logic [15:0] alarmBroadcastWord, bw;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;

  always #25 clk_sys = ~clk_sys;

  battery_status_charge_request uut (.clk_sys, .rst, .clkLink, .linkReqValid,
    .linkCmd, .linkReqReady, .linkRespValid, .linkRespData,
    .linkRespUnsupported, .charging, .primaryTerm, .mahTick, .chargedAccum,
    .fullCap, .maxOvercharge, .tempNow, .otChgSet, .otChgReset, .otDsgSet,
    .otDsgReset, .suspendTempLow, .voltageNow, .cellVoltage,
    .terminateVoltage, .secondEndOfDischargeThreshold, .cellUndervoltageFlag,
    .currentNow, .overloadCurrent, .capacityMode, .remCapCharge,
    .remCapEnergy, .capacityAlarmThreshold, .timeAlarmThreshold,
    .runTimeCurrent, .runTimePower, .avgTimeToFullRaw, .avgTteCurrent,
    .avgTtePower, .relativeChargePercent, .fullyChargedClearPct,
    .batteryLowPct, .flashLoadValid, .flashLoadBad, .errReportValid,
    .errReportCode, .chargeCurrentRaw, .chargeVoltageRaw, .chargerOff,
    .cvModeReq, .ccModeReq, .avgTimeToFull, .avgTimeToEmpty,
    .chargeCurrentRequest, .chargeVoltageRequest, .packStatusWord,
    .alarmBroadcastWord, .alarmBroadcastStrobe);

  link_host_model host (.clkLink, .linkReqValid, .linkCmd, .linkReqReady,
    .linkRespValid, .linkRespData, .linkRespUnsupported);

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic sbit(input logic [15:0] m, input logic v);
    chk(packStatusWord & m, v ? m : 16'h0000);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e,
    input logic eu);
    logic [15:0] d;
    logic u;
    logic ok;
    host.read(c, d, u, ok);
    // back onto the system clock so later stimulus keeps its fixed offset
    step(1);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, e);
    chk({15'h0000, u}, {15'h0000, eu});
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    {primaryTerm, mahTick, cellUndervoltageFlag, capacityMode, flashLoadValid,
      flashLoadBad, errReportValid, chargerOff, cvModeReq, ccModeReq} = '0;
    charging = 1'b1;
    errReportCode = 3'h0;
    relativeChargePercent = 8'h32;
    fullyChargedClearPct = 8'h28;
    batteryLowPct = 8'h0a;
    currentNow = 16'sh0064;
    overloadCurrent = 16'sh1000;
    {chargedAccum, fullCap, maxOvercharge} = {16'h0000, 16'h0400, 16'h0040};
    {tempNow, otChgSet, otChgReset} = {16'h0020, 16'h0050, 16'h0048};
    {otDsgSet, otDsgReset, suspendTempLow} = {16'h0060, 16'h0058, 16'h0000};
    {voltageNow, cellVoltage, terminateVoltage} = {3{16'h3000}};
    terminateVoltage = 16'h2400;
    secondEndOfDischargeThreshold = 16'h2800;
    {remCapCharge, remCapEnergy} = {16'h0200, 16'h0300};
    {capacityAlarmThreshold, timeAlarmThreshold} = {16'h0080, 16'h0010};
    {runTimeCurrent, runTimePower} = {16'h0100, 16'h0180};
    {avgTimeToFullRaw, avgTteCurrent} = {16'h0123, 16'h0200};
    avgTtePower = 16'h0300;
    {chargeCurrentRaw, chargeVoltageRaw} = {16'h05dc, 16'h3138};
    step(5);
    // reset values
    chk(avgTimeToFull, 16'hffff);
    chk(packStatusWord, 16'h0000);
    chk(chargeCurrentRequest, 16'h0000);
    step(1);
    rst = 1'b0;
    step(2);
    chk(avgTimeToFull, 16'h0123);
    avgTimeToFullRaw = 16'hffff;
    step(1);
    chk(avgTimeToFull, 16'hfffe);
    chk(avgTimeToEmpty, 16'hffff);
    sbit(16'h0040, 1'b0);
    chk(chargeVoltageRequest, 16'h3138);
    rd(8'h13, 16'hfffe, 1'b0);
    rd(8'h14, 16'h05dc, 1'b0);
    chargerOff = 1'b1;
    cvModeReq = 1'b1;
    step(1);
    rd(8'h14, 16'h0000, 1'b0);
    chargerOff = 1'b0;
    ccModeReq = 1'b1;
    step(1);
    chk(chargeCurrentRequest, 16'hffff);
    rd(8'h15, 16'hffff, 1'b0);
    {cvModeReq, ccModeReq} = 2'b00;
    // termination raises an alarm and a broadcast
    primaryTerm = 1'b1;
    bw = 16'h0000;
    for (i = 0; i < 4; i++)
    begin
      step(1);
      primaryTerm = 1'b0;
      if (alarmBroadcastStrobe === 1'b1)
        bw = alarmBroadcastWord;
    end
    chk(bw, 16'h4027);
    sbit(16'h4000, 1'b1);
    sbit(16'h0020, 1'b1);
    relativeChargePercent = 8'h1e;
    step(1);
    sbit(16'h0020, 1'b0);
    relativeChargePercent = 8'h32;
    chargedAccum = 16'h0441;
    step(1);
    sbit(16'h8000, 1'b1);
    sbit(16'h0020, 1'b1);
    chargedAccum = 16'h0000;
    charging = 1'b0;
    step(1);
    sbit(16'h4000, 1'b0);
    sbit(16'h0040, 1'b1);
    chk(avgTimeToFull, 16'hffff);
    chk(avgTimeToEmpty, 16'h0200);
    for (i = 0; i < 2; i++)
    begin
      sbit(16'h8000, 1'b1);
      mahTick = 1'b1;
      step(1);
      mahTick = 1'b0;
      step(1);
    end
    sbit(16'h8000, 1'b0);
    capacityMode = 1'b1;
    step(1);
    chk(avgTimeToEmpty, 16'h0300);
    // low-time alarm: power terms hide what current terms would raise
    timeAlarmThreshold = 16'h0140;
    step(2);
    sbit(16'h0100, 1'b0);
    capacityMode = 1'b0;
    step(2);
    sbit(16'h0100, 1'b1);
    timeAlarmThreshold = 16'h0010;
    step(2);
    sbit(16'h0100, 1'b0);
    tempNow = 16'h0060;
    step(1);
    sbit(16'h1000, 1'b1);
    tempNow = 16'h0059;
    step(1);
    sbit(16'h1000, 1'b1);
    tempNow = 16'h0057;
    step(1);
    sbit(16'h1000, 1'b0);
    remCapCharge = 16'h0000;
    step(1);
    sbit(16'h0a00, 1'b1);
    chk(packStatusWord & 16'h2400, 16'h0000);
    remCapCharge = 16'h0200;
    step(1);
    sbit(16'h0a00, 1'b0);
    capacityMode = 1'b1;
    remCapEnergy = 16'h0000;
    step(1);
    sbit(16'h0800, 1'b1);
    {capacityMode, remCapEnergy} = {1'b0, 16'h0300};
    step(1);
    sbit(16'h0800, 1'b0);
    voltageNow = 16'h2400;
    step(1);
    sbit(16'h0800, 1'b1);
    voltageNow = 16'h3000;
    step(1);
    sbit(16'h0800, 1'b0);
    flashLoadValid = 1'b1;
    step(1);
    flashLoadValid = 1'b0;
    sbit(16'h0080, 1'b1);
    flashLoadBad = 1'b1;
    step(1);
    flashLoadBad = 1'b0;
    sbit(16'h0080, 1'b0);
    relativeChargePercent = 8'h05;
    step(1);
    sbit(16'h0020, 1'b0);
    sbit(16'h0010, 1'b1);
    relativeChargePercent = 8'h13;
    step(1);
    sbit(16'h0010, 1'b1);
    relativeChargePercent = 8'h14;
    step(1);
    sbit(16'h0010, 1'b0);
    voltageNow = 16'h2600;
    step(1);
    sbit(16'h0010, 1'b1);
    voltageNow = 16'h3000;
    step(1);
    sbit(16'h0010, 1'b0);
    rd(8'h16, 16'h0040, 1'b0);
    rd(8'h20, 16'h0000, 1'b1);
    chk(packStatusWord & 16'h0007, 16'h0003);
    for (i = 0; i < 8; i++)
    begin
      errReportCode = i[2:0];
      errReportValid = 1'b1;
      step(1);
      errReportValid = 1'b0;
      chk(packStatusWord & 16'h0007, {13'h0000, i[2:0]});
    end
    rd(8'h13, 16'hffff, 1'b0);
    chk(packStatusWord & 16'h0007, 16'h0000);
    final_report();
  end
endmodule

`default_nettype wire
